// *** logic/sps_pkg.sv ***
// package: constants and carriers for the switch port status register group
package sps_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses in configuration space)
  // ----------------------------------------------------------------
  localparam logic [11:0] SPS_OFF_PORT_CFG   = 12'h574;
  localparam logic [11:0] SPS_OFF_EN_MAP     = 12'h668;
  localparam logic [11:0] SPS_OFF_WIDTH_A    = 12'h66C;
  localparam logic [11:0] SPS_OFF_WIDTH_B    = 12'h670;
  localparam logic [11:0] SPS_OFF_LINK_UP    = 12'h674;
  localparam int          SPS_NUM_WIN        = 7;
  localparam logic [11:0] SPS_OFF_WIN [SPS_NUM_WIN] =
    '{12'h680, 12'h684, 12'h690, 12'h694, 12'h698, 12'h6A0, 12'h6A4};

  // ----------------------------------------------------------------
  // station first ports; only these hold enable, width and window words
  // ----------------------------------------------------------------
  localparam logic [3:0]  SPS_STN0_PORT      = 4'h0;
  localparam logic [3:0]  SPS_STN1_PORT      = 4'h4;
  localparam logic [3:0]  SPS_STN2_PORT      = 4'h8;

  // ----------------------------------------------------------------
  // trained links: ports 0, 1, 5, 6, 8, 9
  // ----------------------------------------------------------------
  localparam int          SPS_NUM_LINK       = 6;
  localparam int          SPS_LINK_BIT [SPS_NUM_LINK] = '{0, 1, 5, 6, 8, 9};
  localparam int          SPS_WID_LSB  [SPS_NUM_LINK] = '{0, 4, 20, 24, 0, 4};
  localparam bit          SPS_IN_WORD_B[SPS_NUM_LINK] = '{0, 0, 0, 0, 1, 1};
  localparam int          SPS_SPEED_POS      = 3;

  // ----------------------------------------------------------------
  // width codes and station configuration codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  SPS_W_X1           = 3'h0;
  localparam logic [2:0]  SPS_W_X4           = 3'h2;
  localparam logic [2:0]  SPS_W_X8           = 3'h3;
  localparam logic [1:0]  SPS_CFG_X4X4       = 2'h0;
  localparam logic [1:0]  SPS_CFG_X8         = 2'h2;
  localparam logic [1:0]  SPS_CFG_S1_X4X4    = 2'h3;
  localparam int          SPS_CFG_S0_LSB     = 0;
  localparam int          SPS_CFG_S1_LSB     = 2;
  localparam int          SPS_CFG_S2_LSB     = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] SPS_RST_WORD       = 32'h0000_0000;
  localparam logic [9:0]  SPS_RST_MAP        = 10'h000;
  localparam logic [3:0]  SPS_RST_FIELD      = 4'h0;

  // status of one trained link
  typedef struct packed {
    logic       up;
    logic [2:0] width;
    logic       gen2;
  } sps_link_t;

  // configuration access from software
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [3:0]  port;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] data;
  } sps_cfg_req_t;

  // serial EEPROM / I2C loader write
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] data;
  } sps_ld_req_t;

  typedef enum logic {
    SPS_ST_STRAP = 1'b0,
    SPS_ST_RUN   = 1'b1
  } sps_state_t;

endpackage

// *** logic/sps_port_status_regs.sv ***
// module: port enable, trained width, link-up and I/O window registers
// ------------------------------------------------------------------
// Summary of operation
// - ports 8/9 enable bits follow station 2
// - station 0 code: x4+x4 or x8
// - station 1 code: port 5 x8 or 5/6 x4
// - station 2 code: x4+x4 or x8
// - width field three-bit code, resets zero
// - speed bit: 0 2.5, 1 5.0 GT/s
// - first width word layout, ports 1/6 x4 max
// - second width word layout, port 9 x4 max
// - cut-through bit equals link up of an enabled port
// - cut-through bit positions, reserved bits zero
// - link-up word everywhere, others station ports
// - window low half is I/O base
// - window high half is I/O limit
// - window words at fixed offsets per port
// - ports 0/1 enable bits follow station 0
// - ports 5/6 enable bits follow station 1
// ------------------------------------------------------------------
module sps_port_status_regs
  import sps_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic                station0_lane_split_pin,
  input  wire logic                station0_spare_pin,
  input  wire logic                station1_lane_split_pin,
  input  wire logic                station1_spare_pin,
  input  wire logic                station2_lane_split_pin,
  input  wire logic                station2_spare_pin,
  input  wire sps_link_t           linkIn [SPS_NUM_LINK],
  input  wire sps_cfg_req_t        cfgReq,
  input  wire sps_ld_req_t         ldReq,
  output logic [31:0]              cfgRdData,
  output logic                     cfgRdValid,
  output logic [9:0]               portEnabled,
  output logic [9:0]               cutThroughEn,
  output logic [5:0]               stationCfg,
  output logic [31:0]              ioWindow [SPS_NUM_WIN]
);

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  // window index for an address, SPS_NUM_WIN when no window matches
  function automatic logic [2:0] win_index(input logic [11:0] addr);
    logic [2:0] idx;
    idx = 3'(SPS_NUM_WIN);
    for (int i = 0; i < SPS_NUM_WIN; i++) begin
      if (addr == SPS_OFF_WIN[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // station-scoped words live only in ports 0, 4 and 8
  function automatic logic is_station_port(input logic [3:0] port);
    return (port == SPS_STN0_PORT) || (port == SPS_STN1_PORT) ||
           (port == SPS_STN2_PORT);
  endfunction

  // byte-lane merge for a software write
  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wdat,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ------------------------------------------------------------------
  // station configuration: straps at release, loader may override
  // ------------------------------------------------------------------
  sps_state_t  state_q;
  sps_state_t  state_d;
  logic [5:0]  stnCfg_q;
  logic [5:0]  stnCfg_d;

  // straps caught one edge after reset release, never under reset itself
  always_comb begin
    state_d  = state_q;
    stnCfg_d = stnCfg_q;
    case (state_q)
      SPS_ST_STRAP: begin
        stnCfg_d[SPS_CFG_S0_LSB +: 2] = {station0_lane_split_pin,
                                         station0_spare_pin};
        stnCfg_d[SPS_CFG_S1_LSB +: 2] = {station1_spare_pin,
                                         station1_lane_split_pin};
        stnCfg_d[SPS_CFG_S2_LSB +: 2] = {station2_lane_split_pin,
                                         station2_spare_pin};
        state_d = SPS_ST_RUN;
      end
      SPS_ST_RUN: begin
        // loader image of the port configuration field wins afterwards
        if (ldReq.wr && ldReq.addr == SPS_OFF_PORT_CFG) begin
          stnCfg_d = ldReq.data[5:0];
        end
      end
      default: begin
        state_d = SPS_ST_STRAP;
      end
    endcase
  end

  // station configuration registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q  <= SPS_ST_STRAP;
      stnCfg_q <= 6'h00;
    end else begin
      state_q  <= state_d;
      stnCfg_q <= stnCfg_d;
    end
  end

  // ------------------------------------------------------------------
  // lane split per station: enables and widest allowed code per link
  // ------------------------------------------------------------------
  logic [1:0] cfg0;
  logic [1:0] cfg1;
  logic [1:0] cfg2;
  logic [9:0] enMap;
  logic [2:0] maxCode [SPS_NUM_LINK];

  assign cfg0 = stnCfg_q[SPS_CFG_S0_LSB +: 2];
  assign cfg1 = stnCfg_q[SPS_CFG_S1_LSB +: 2];
  assign cfg2 = stnCfg_q[SPS_CFG_S2_LSB +: 2];

  // reserved codes fall back to x4+x4 on stations 0 and 2, to port 5 x8 on station 1
  always_comb begin
    enMap = SPS_RST_MAP;
    enMap[SPS_LINK_BIT[0]] = 1'b1;
    enMap[SPS_LINK_BIT[1]] = (cfg0 != SPS_CFG_X8);
    enMap[SPS_LINK_BIT[2]] = 1'b1;
    enMap[SPS_LINK_BIT[3]] = (cfg1 == SPS_CFG_S1_X4X4);
    enMap[SPS_LINK_BIT[4]] = 1'b1;
    enMap[SPS_LINK_BIT[5]] = (cfg2 != SPS_CFG_X8);
    maxCode[0] = (cfg0 == SPS_CFG_X8) ? SPS_W_X8 : SPS_W_X4;
    maxCode[1] = SPS_W_X4;
    maxCode[2] = (cfg1 == SPS_CFG_S1_X4X4) ? SPS_W_X4 : SPS_W_X8;
    maxCode[3] = SPS_W_X4;
    maxCode[4] = (cfg2 == SPS_CFG_X8) ? SPS_W_X8 : SPS_W_X4;
    maxCode[5] = SPS_W_X4;
  end

  // ------------------------------------------------------------------
  // trained width, speed and link-up capture per link
  // ------------------------------------------------------------------
  logic [3:0] field_q [SPS_NUM_LINK];
  logic [3:0] field_d [SPS_NUM_LINK];
  logic [9:0] cut_q;
  logic [9:0] cut_d;
  logic [9:0] en_q;

  genvar gl;
  generate
    for (gl = 0; gl < SPS_NUM_LINK; gl++) begin : gLink
      // a down or disabled link reports x1 at 2.5 GT/s
      always_comb begin
        field_d[gl] = SPS_RST_FIELD;
        if (linkIn[gl].up && enMap[SPS_LINK_BIT[gl]]) begin
          // over-wide or reserved codes clamp to the split's maximum
          field_d[gl][2:0] = (linkIn[gl].width > maxCode[gl]) ?
                             maxCode[gl] : linkIn[gl].width;
          field_d[gl][SPS_SPEED_POS] = linkIn[gl].gen2;
        end
      end

      // width and speed field register
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          field_q[gl] <= SPS_RST_FIELD;
        end else begin
          field_q[gl] <= field_d[gl];
        end
      end
    end
  endgenerate

  // cut-through follows link up of enabled ports only
  always_comb begin
    cut_d = SPS_RST_MAP;
    for (int i = 0; i < SPS_NUM_LINK; i++) begin
      cut_d[SPS_LINK_BIT[i]] = linkIn[i].up & enMap[SPS_LINK_BIT[i]];
    end
  end

  // status map registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cut_q <= SPS_RST_MAP;
      en_q  <= SPS_RST_MAP;
    end else begin
      cut_q <= cut_d;
      en_q  <= enMap;
    end
  end

  // ------------------------------------------------------------------
  // I/O window words
  // ------------------------------------------------------------------
  logic [31:0] win_q [SPS_NUM_WIN];
  logic [31:0] win_d [SPS_NUM_WIN];
  logic [2:0]  swIdx;
  logic [2:0]  ldIdx;
  logic        swWinWr;

  assign swIdx   = win_index(cfgReq.addr);
  assign ldIdx   = win_index(ldReq.addr);
  assign swWinWr = cfgReq.wr && is_station_port(cfgReq.port);

  // loader write wins over a software write to the same word
  always_comb begin
    for (int i = 0; i < SPS_NUM_WIN; i++) begin
      win_d[i] = win_q[i];
      if (swWinWr && swIdx == 3'(i)) begin
        win_d[i] = merge_be(win_q[i], cfgReq.data, cfgReq.be);
      end
      if (ldReq.wr && ldIdx == 3'(i)) begin
        win_d[i] = ldReq.data;
      end
    end
  end

  // window registers, base in 15:0 and limit in 31:16
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SPS_NUM_WIN; i++) begin
        win_q[i] <= SPS_RST_WORD;
      end
    end else begin
      for (int i = 0; i < SPS_NUM_WIN; i++) begin
        win_q[i] <= win_d[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // read path: one-cycle registered answer
  // ------------------------------------------------------------------
  logic [31:0] wordA;
  logic [31:0] wordB;
  logic [31:0] rdMux;
  logic [31:0] rdData_q;
  logic        rdValid_q;

  // test-only and reserved positions stay zero
  always_comb begin
    wordA = SPS_RST_WORD;
    wordB = SPS_RST_WORD;
    for (int i = 0; i < SPS_NUM_LINK; i++) begin
      if (SPS_IN_WORD_B[i]) begin
        wordB[SPS_WID_LSB[i] +: 4] = field_q[i];
      end else begin
        wordA[SPS_WID_LSB[i] +: 4] = field_q[i];
      end
    end
  end

  // writes to read-only words simply find no register to land in
  always_comb begin
    rdMux = SPS_RST_WORD;
    if (cfgReq.addr == SPS_OFF_LINK_UP) begin
      rdMux = {22'h0, cut_q};
    end else if (is_station_port(cfgReq.port)) begin
      if (cfgReq.addr == SPS_OFF_EN_MAP) begin
        rdMux = {22'h0, en_q};
      end else if (cfgReq.addr == SPS_OFF_WIDTH_A) begin
        rdMux = wordA;
      end else if (cfgReq.addr == SPS_OFF_WIDTH_B) begin
        rdMux = wordB;
      end else if (swIdx != 3'(SPS_NUM_WIN)) begin
        rdMux = win_q[swIdx];
      end
    end
  end

  // read data holds until the next read
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_q  <= SPS_RST_WORD;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= cfgReq.rd;
      if (cfgReq.rd) begin
        rdData_q <= rdMux;
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from flops
  // ------------------------------------------------------------------
  assign cfgRdData    = rdData_q;
  assign cfgRdValid   = rdValid_q;
  assign portEnabled  = en_q;
  assign cutThroughEn = cut_q;
  assign stationCfg   = stnCfg_q;
  assign ioWindow     = win_q;

endmodule

// *** test/sps_port_status_props.sv ***
// checker: timing and value properties of the port status register group
module sps_port_status_props
  import sps_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         rst_b,
  input wire logic         station0_lane_split_pin,
  input wire logic         station0_spare_pin,
  input wire logic         station1_lane_split_pin,
  input wire logic         station1_spare_pin,
  input wire logic         station2_lane_split_pin,
  input wire logic         station2_spare_pin,
  input wire sps_link_t    linkIn [SPS_NUM_LINK],
  input wire sps_cfg_req_t cfgReq,
  input wire sps_ld_req_t  ldReq,
  input wire logic [31:0]  cfgRdData,
  input wire logic         cfgRdValid,
  input wire logic [9:0]   portEnabled,
  input wire logic [9:0]   cutThroughEn,
  input wire logic [5:0]   stationCfg,
  input wire logic [31:0]  ioWindow [SPS_NUM_WIN]
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic [1:0] upCnt_q;
  logic [1:0] upCnt_d;
  logic [9:0] upMap;
  // settle counter: the enable map lags the strap capture by one edge
  always_comb begin
    upCnt_d = (upCnt_q == 2'h3) ? upCnt_q : upCnt_q + 2'h1;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      upCnt_q <= 2'h0;
    end else begin
      upCnt_q <= upCnt_d;
    end
  end
  // link-up per port bit; cut bits lag it by one edge, in step with the enable map
  always_comb begin
    upMap = 10'h000;
    for (int i = 0; i < SPS_NUM_LINK; i++) begin
      upMap[SPS_LINK_BIT[i]] = linkIn[i].up;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence rdAt(logic [11:0] a, logic [3:0] p);
    cfgReq.rd && cfgReq.addr == a && cfgReq.port == p;
  endsequence
  sequence swWin0;
    cfgReq.wr && !ldReq.wr && cfgReq.port == SPS_STN0_PORT
      && cfgReq.addr == SPS_OFF_WIN[0] && cfgReq.be == 4'hF;
  endsequence
  cut_reserved_a: assert property (rdAt(SPS_OFF_LINK_UP, 4'h9) |=> cfgRdValid
    && cfgRdData[31:10] == 22'h0 && (cfgRdData & 32'h0000_009C) == 32'h0)
    else $error("link-up word read shows reserved bits or no answer");
  rd_hold_a: assert property (!cfgReq.rd |=> !cfgRdValid && $stable(cfgRdData))
    else $error("read answer moved without a read");
  cut_follow_a: assert property (cutThroughEn == ($past(upMap) & portEnabled))
    else $error("cut-through bits do not follow link up");
  width_a_fmt_a: assert property (rdAt(SPS_OFF_WIDTH_A, 4'h0) |=>
    cfgRdData[6:4] <= SPS_W_X4 && cfgRdData[26:24] <= SPS_W_X4
    && cfgRdData[19:8] == 12'h0 && cfgRdData[31:28] == 4'h0)
    else $error("first width word out of range");
  width_b_fmt_a: assert property (rdAt(SPS_OFF_WIDTH_B, 4'h4) |=>
    cfgRdData[6:4] <= SPS_W_X4 && cfgRdData[31:8] == 24'h0)
    else $error("second width word out of range");
  width_nonstn_a: assert property (rdAt(SPS_OFF_WIDTH_A, 4'h1) |=> cfgRdData == 32'h0)
    else $error("width word visible outside station port");
  st0_enable_a: assert property (upCnt_q == 2'h3 |-> portEnabled[1:0] ==
    (($past(stationCfg[1:0]) == SPS_CFG_X8) ? 2'h1 : 2'h3))
    else $error("ports 0 and 1 enable wrong");
  st1_enable_a: assert property (upCnt_q == 2'h3 |-> portEnabled[6:5] ==
    (($past(stationCfg[3:2]) == SPS_CFG_S1_X4X4) ? 2'h3 : 2'h1))
    else $error("ports 5 and 6 enable wrong");
  st2_enable_a: assert property (upCnt_q == 2'h3 |-> portEnabled[9:8] ==
    (($past(stationCfg[5:4]) == SPS_CFG_X8) ? 2'h1 : 2'h3))
    else $error("ports 8 and 9 enable wrong");
  win_sw_a: assert property (swWin0 |=> ioWindow[0] == $past(cfgReq.data))
    else $error("window word of port 0 not written");
  win_ld_a: assert property (ldReq.wr && ldReq.addr == SPS_OFF_WIN[6] |=>
    ioWindow[6] == $past(ldReq.data))
    else $error("loader write to port 9 window lost");
  ro_write_a: assert property (cfgReq.wr && !ldReq.wr && cfgReq.addr == SPS_OFF_EN_MAP
    |=> $stable(stationCfg) && (portEnabled & 10'h09C) == 10'h000)
    else $error("write to enable map had an effect");
endmodule
bind sps_port_status_regs sps_port_status_props i_sps_port_status_props (
  .ref_clk                 (ref_clk),
  .rst_b                   (rst_b),
  .station0_lane_split_pin (station0_lane_split_pin),
  .station0_spare_pin      (station0_spare_pin),
  .station1_lane_split_pin (station1_lane_split_pin),
  .station1_spare_pin      (station1_spare_pin),
  .station2_lane_split_pin (station2_lane_split_pin),
  .station2_spare_pin      (station2_spare_pin),
  .linkIn                  (linkIn),
  .cfgReq                  (cfgReq),
  .ldReq                   (ldReq),
  .cfgRdData               (cfgRdData),
  .cfgRdValid              (cfgRdValid),
  .portEnabled             (portEnabled),
  .cutThroughEn            (cutThroughEn),
  .stationCfg              (stationCfg),
  .ioWindow                (ioWindow)
);

// *** test/tb.sv ***
// testbench: directed scenarios for the port status register group
`define CHK(g, e, m) begin samplesChecked++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e); end end
module tb
  import sps_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic         ref_clk = 1'b0;
  logic         rst_b = 1'b0;
  logic [5:0]   strap = 6'h04; // s0 split,spare; s1 split,spare; s2 split,spare
  sps_link_t    linkIn [SPS_NUM_LINK];
  sps_cfg_req_t cfgReq;
  sps_ld_req_t  ldReq;
  logic [31:0]  cfgRdData;
  logic         cfgRdValid;
  logic [9:0]   portEnabled;
  logic [9:0]   cutThroughEn;
  logic [5:0]   stationCfg;
  logic [31:0]  ioWindow [SPS_NUM_WIN];
  int           mismatches = 0;
  int           samplesChecked = 0;
  sps_port_status_regs i_sps_port_status_regs (
    .ref_clk(ref_clk), .rst_b(rst_b),
    .station0_lane_split_pin(strap[5]), .station0_spare_pin(strap[4]),
    .station1_lane_split_pin(strap[3]), .station1_spare_pin(strap[2]),
    .station2_lane_split_pin(strap[1]), .station2_spare_pin(strap[0]),
    .linkIn(linkIn), .cfgReq(cfgReq), .ldReq(ldReq), .cfgRdData(cfgRdData),
    .cfgRdValid(cfgRdValid), .portEnabled(portEnabled), .cutThroughEn(cutThroughEn),
    .stationCfg(stationCfg), .ioWindow(ioWindow));
  always #4 ref_clk = ~ref_clk;
  // ----------------------------------------
  // bus tasks, entered on a falling edge except the first reset at time zero
  // ----------------------------------------
  // each task idles one cycle after dropping its strobe, so a following
  // call never raises it again in the same time step
  task automatic do_reset(input logic [5:0] s);
    rst_b = 1'b0;
    strap = s;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] p, input logic [11:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    cfgReq = '{rd: 1'b0, wr: 1'b1, port: p, addr: a, be: be, data: d};
    @(negedge ref_clk);
    cfgReq.wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic ld(input logic [11:0] a, input logic [31:0] d);
    ldReq = '{wr: 1'b1, addr: a, data: d};
    @(negedge ref_clk);
    ldReq.wr = 1'b0;
    @(negedge ref_clk);
  endtask
  // read answer is a one-cycle pulse, so it is judged at the next falling edge
  task automatic rd(input logic [3:0] p, input logic [11:0] a, input logic [31:0] e);
    cfgReq = '{rd: 1'b1, wr: 1'b0, port: p, addr: a, be: 4'h0, data: 32'h0};
    @(negedge ref_clk);
    `CHK(cfgRdValid, 1'b1, "read valid")
    `CHK(cfgRdData, e, "read data")
    cfgReq.rd = 1'b0;
    @(negedge ref_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_vals();
    for (int i = 0; i < SPS_NUM_WIN; i++) rd(4'h0, SPS_OFF_WIN[i], 32'h0);
    rd(4'h0, SPS_OFF_LINK_UP, 32'h0);
    rd(4'h0, SPS_OFF_WIDTH_A, 32'h0);
    rd(4'h8, SPS_OFF_WIDTH_B, 32'h0);
    rd(4'h4, SPS_OFF_EN_MAP, 32'h0000_0323);
    `CHK(stationCfg, 6'h08, "strap codes")
    $display("test reset values done");
  endtask
  // station codes given by the loader, enable map one edge later
  task automatic t_load_cfg(input logic [5:0] c, input logic [9:0] en);
    ld(SPS_OFF_PORT_CFG, {26'h0, c});
    @(negedge ref_clk);
    `CHK(stationCfg, c, "loaded codes")
    `CHK(portEnabled, en, "enable map")
    rd(4'h8, SPS_OFF_EN_MAP, {22'h0, en});
    rd(4'h0, SPS_OFF_EN_MAP, {22'h0, en});
    rd(4'h4, SPS_OFF_EN_MAP, {22'h0, en});
    $display("test loaded config done");
  endtask
  // widths clamp to the station's lane split; disabled ports read zero
  task automatic t_links(input logic [31:0] wa, input logic [31:0] wb, input logic [9:0] cut);
    repeat (3) @(negedge ref_clk);
    rd(4'h0, SPS_OFF_WIDTH_A, wa);
    rd(4'h4, SPS_OFF_WIDTH_B, wb);
    rd(4'h0, SPS_OFF_LINK_UP, {22'h0, cut});
    rd(4'h9, SPS_OFF_LINK_UP, {22'h0, cut});
    rd(4'h1, SPS_OFF_WIDTH_A, 32'h0);
    $display("test links done");
  endtask
  task automatic t_windows();
    logic [31:0] v;
    for (int i = 0; i < SPS_NUM_WIN; i++) wr(4'h0, SPS_OFF_WIN[i], 4'hF, 32'hC000_5000 + i);
    for (int i = 0; i < SPS_NUM_WIN; i++) begin
      v = 32'hC000_5000 + i;
      rd(4'h4, SPS_OFF_WIN[i], v);
      `CHK(ioWindow[i], v, "window word")
    end
    wr(4'h0, SPS_OFF_WIN[0], 4'h3, 32'hFFFF_1234); // base half only
    rd(4'h0, SPS_OFF_WIN[0], 32'hC000_1234);
    wr(4'h5, SPS_OFF_WIN[1], 4'hF, 32'h0); // not a station port
    rd(4'h0, SPS_OFF_WIN[1], 32'hC000_5001);
    wr(4'h0, SPS_OFF_EN_MAP, 4'hF, 32'hFFFF_0323);
    rd(4'h0, SPS_OFF_EN_MAP, 32'h0000_0323);
    rd(4'h0, 12'h6B0, 32'h0);
    ldReq = '{wr: 1'b1, addr: SPS_OFF_WIN[6], data: 32'h00AB_0012};
    wr(4'h0, SPS_OFF_WIN[6], 4'hF, 32'h5555_5555);
    ldReq.wr = 1'b0;
    rd(4'h8, SPS_OFF_WIN[6], 32'h00AB_0012);
    $display("test windows done");
  endtask
  // straps of the second reset: other lane splits, windows back to zero
  task automatic t_reset_again();
    `CHK(stationCfg, 6'h2E, "strap codes")
    rd(4'h0, SPS_OFF_WIN[0], 32'h0);
    $display("test second reset done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    #50000;
    mismatches++;
    final_report();
  end
  initial begin
    cfgReq = '0;
    ldReq = '0;
    for (int i = 0; i < SPS_NUM_LINK; i++) linkIn[i] = '0;
    do_reset(6'h04);
    t_reset_vals();
    t_load_cfg(6'h2E, 10'h161);
    t_load_cfg(6'h08, 10'h323);
    // ports 0,1,5,6,8,9: x8, x8, x8, x8, x1, x2 with mixed speeds
    linkIn = '{'{1'b1, SPS_W_X8, 1'b1}, '{1'b1, SPS_W_X8, 1'b0}, '{1'b1, SPS_W_X8, 1'b1},
               '{1'b1, SPS_W_X8, 1'b0}, '{1'b1, SPS_W_X1, 1'b0}, '{1'b1, 3'h1, 1'b1}};
    t_links(32'h00B0_002A, 32'h0000_0090, 10'h323);
    t_windows();
    do_reset(6'h2E); // second reset with the other lane splits strapped
    t_reset_again();
    t_links(32'h02A0_000B, 32'h0, 10'h161);
    linkIn[0].up = 1'b0;
    t_links(32'h02A0_0000, 32'h0, 10'h160);
    final_report();
  end
endmodule
